// ==== rtl/fspr_cfg.svh ====
`ifndef FSPR_CFG_SVH
`define FSPR_CFG_SVH
// ----------------------------------------
// Timing figures and clock rate
// ----------------------------------------
`define FSPR_CLK_MHZ          100
`define FSPR_RP_BUSY_US       10
`define FSPR_READY_BUSY_US    20
`define FSPR_RP_IDLE_NS       500
`define FSPR_READY_IDLE_NS    500
`define FSPR_RB_WRITE_NS      50
`define FSPR_WPP1_US          10
`define FSPR_WPP2_MS          12
`define FSPR_VLHT_US          4
`define FSPR_ACC_NS           120
// ----------------------------------------
// Derived cycle counts (least times round up)
// ----------------------------------------
`define FSPR_RP_BUSY_CYC      (`FSPR_RP_BUSY_US * `FSPR_CLK_MHZ)
`define FSPR_READY_BUSY_CYC   (`FSPR_READY_BUSY_US * `FSPR_CLK_MHZ)
`define FSPR_RP_IDLE_CYC      ((`FSPR_RP_IDLE_NS * `FSPR_CLK_MHZ + 999) / 1000)
`define FSPR_READY_IDLE_CYC   ((`FSPR_READY_IDLE_NS * `FSPR_CLK_MHZ + 999) / 1000)
`define FSPR_RB_WRITE_CYC     ((`FSPR_RB_WRITE_NS * `FSPR_CLK_MHZ + 999) / 1000)
`define FSPR_WPP1_CYC         (`FSPR_WPP1_US * `FSPR_CLK_MHZ)
`define FSPR_WPP2_CYC         (`FSPR_WPP2_MS * 1000 * `FSPR_CLK_MHZ)
`define FSPR_VLHT_CYC         (`FSPR_VLHT_US * `FSPR_CLK_MHZ)
`define FSPR_ACC_CYC          ((`FSPR_ACC_NS * `FSPR_CLK_MHZ + 999) / 1000)
// ----------------------------------------
// Command bytes of the identity query and of the reset command
// ----------------------------------------
`define FSPR_UNLOCK1_ADDR     12'h555
`define FSPR_UNLOCK2_ADDR     12'hAAA
`define FSPR_UNLOCK1_DATA     8'hAA
`define FSPR_UNLOCK2_DATA     8'h55
`define FSPR_IDQ_DATA         8'h90
`define FSPR_RESET_DATA       8'hF0
`endif

// ==== rtl/fspr_pkg.sv ====
package fspr_pkg;
  // Operations the host can request
  typedef enum logic [2:0] {
    FSPR_OP_PROTECT,
    FSPR_OP_UNPROTECT,
    FSPR_OP_VERIFY,
    FSPR_OP_QUERY,
    FSPR_OP_RESET,
    FSPR_OP_TEMP_ON,
    FSPR_OP_TEMP_OFF
  } fspr_op_t;
endpackage

// ==== rtl/fspr_timer.sv ====
`timescale 1ns/1ps
// Down counter that pulses done_o after load_val_i cycles
module fspr_timer #(
  parameter int W = 21
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic              done_o
);
  logic [W-1:0] count;
  logic         run;

  initial begin
    if (W < 4) $error("fspr_timer width too small");
  end

  // Count down, flag at terminal count
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count  <= '0;
      run    <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      count  <= load_val_i;
      run    <= 1'b1;
      done_o <= 1'b0;
    end else if (run) begin
      if (count <= W'(1)) begin
        run    <= 1'b0;
        done_o <= 1'b1;
      end else begin
        count <= count - W'(1);
      end
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule

// ==== rtl/fspr_host.sv ====
`timescale 1ns/1ps
`include "fspr_cfg.svh"
module fspr_host
  import fspr_pkg::*;
#(
  parameter int AW           = 18,
  parameter int RP_BUSY_CYC  = `FSPR_RP_BUSY_CYC,
  parameter int RDY_BUSY_CYC = `FSPR_READY_BUSY_CYC,
  parameter int WPP1_CYC     = `FSPR_WPP1_CYC,
  parameter int WPP2_CYC     = `FSPR_WPP2_CYC
) (
  input  wire logic          clock_i,
  input  wire logic          resetn_i,
  input  wire logic          req_i,
  input  wire fspr_op_t      op_i,
  input  wire logic [AW-1:0] sector_addr_i,
  input  wire logic          alg_busy_i,
  input  wire logic [7:0]    low_data_outputs_i,
  input  wire logic          ready_busy_line_i,
  output logic               busy_o,
  output logic               done_o,
  output logic [7:0]         rd_data_o,
  output logic               protected_o,
  output logic [AW-1:0]      addr_o,
  output logic [7:0]         wdata_o,
  output logic               wdata_oe_o,
  output logic               chip_sel_n_o,
  output logic               out_strobe_n_o,
  output logic               write_strobe_n_o,
  output logic               hw_reset_n_o,
  output logic               hv_addr_en_o,
  output logic               hv_oe_en_o,
  output logic               hv_reset_en_o
);
  localparam int PSEL = 6;
  localparam int IDPG = 1;
  localparam int HVA  = 9;
  localparam int TW   = 21;

  typedef enum logic [3:0] {
    FSPR_IDLE, FSPR_HV_SETUP, FSPR_WPULSE, FSPR_HV_DROP, FSPR_RD_WAIT,
    FSPR_CMD_SETUP, FSPR_CMD_LOW, FSPR_CMD_HIGH, FSPR_RST_LOW, FSPR_RST_WAIT, FSPR_RB_WAIT
  } fspr_state_t;

  fspr_state_t   state;
  fspr_op_t      op;
  logic [1:0]    cmd_idx;
  logic          tload;
  logic [TW-1:0] tval;
  logic          tdone;
  logic          rdy_q;

  initial begin
    if (AW <= HVA) $error("fspr_host address too narrow");
    if (WPP2_CYC >= (1 << TW)) $error("fspr_host timer too narrow");
  end

  // Command address and data of each cycle of the query or reset command
  function automatic logic [19:0] fspr_cmd(input logic [1:0] idx, input logic reset_cmd);
    case (idx)
      2'd0:    fspr_cmd = {`FSPR_UNLOCK1_ADDR, `FSPR_UNLOCK1_DATA};
      2'd1:    fspr_cmd = {`FSPR_UNLOCK2_ADDR, `FSPR_UNLOCK2_DATA};
      default: fspr_cmd = {`FSPR_UNLOCK1_ADDR, reset_cmd ? `FSPR_RESET_DATA : `FSPR_IDQ_DATA};
    endcase
  endfunction

  fspr_timer #(
    .W (TW)
  ) u_timer (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .load_i     (tload),
    .load_val_i (tval),
    .done_o     (tdone)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state            <= FSPR_IDLE;
      op               <= FSPR_OP_VERIFY;
      cmd_idx          <= 2'd0;
      tload            <= 1'b0;
      tval             <= '0;
      busy_o           <= 1'b0;
      done_o           <= 1'b0;
      rd_data_o        <= 8'h00;
      protected_o      <= 1'b0;
      addr_o           <= '0;
      wdata_o          <= 8'h00;
      wdata_oe_o       <= 1'b0;
      chip_sel_n_o     <= 1'b1;
      out_strobe_n_o   <= 1'b1;
      write_strobe_n_o <= 1'b1;
      hw_reset_n_o     <= 1'b1;
      hv_addr_en_o     <= 1'b0;
      hv_oe_en_o       <= 1'b0;
      hv_reset_en_o    <= 1'b0;
    end else begin
      tload  <= 1'b0;
      done_o <= 1'b0;
      case (state)
        FSPR_IDLE: begin
          if (req_i) begin
            op     <= op_i;
            busy_o <= 1'b1;
            addr_o <= sector_addr_i;
            case (op_i)
              FSPR_OP_PROTECT, FSPR_OP_UNPROTECT: begin
                // Raise high voltage on address pin and output strobe
                hv_addr_en_o   <= 1'b1;
                hv_oe_en_o     <= 1'b1;
                chip_sel_n_o   <= 1'b0;
                addr_o[PSEL]   <= (op_i == FSPR_OP_UNPROTECT);
                tval           <= TW'(`FSPR_VLHT_CYC);
                tload          <= 1'b1;
                state          <= FSPR_HV_SETUP;
              end
              FSPR_OP_VERIFY: begin
                hv_addr_en_o   <= 1'b1;
                addr_o[IDPG]   <= 1'b1;
                chip_sel_n_o   <= 1'b0;
                tval           <= TW'(`FSPR_VLHT_CYC);
                tload          <= 1'b1;
                state          <= FSPR_RD_WAIT;
              end
              FSPR_OP_QUERY, FSPR_OP_RESET: begin
                cmd_idx <= 2'd0;
                state   <= FSPR_RB_WAIT;
              end
              FSPR_OP_TEMP_ON: begin
                hv_reset_en_o <= 1'b1;
                done_o        <= 1'b1;
                busy_o        <= 1'b0;
              end
              default: begin
                // Hardware reset, length chosen from algorithm state
                hv_reset_en_o <= 1'b0;
                hw_reset_n_o  <= 1'b0;
                tval  <= alg_busy_i ? TW'(RP_BUSY_CYC) : TW'(`FSPR_RP_IDLE_CYC);
                tload <= 1'b1;
                state <= FSPR_RST_LOW;
              end
            endcase
          end
        end
        FSPR_HV_SETUP: if (tdone) begin
          write_strobe_n_o <= 1'b0;
          tval  <= (op == FSPR_OP_UNPROTECT) ? TW'(WPP2_CYC) : TW'(WPP1_CYC);
          tload <= 1'b1;
          state <= FSPR_WPULSE;
        end
        FSPR_WPULSE: if (tdone) begin
          write_strobe_n_o <= 1'b1;
          tval  <= TW'(`FSPR_VLHT_CYC);
          tload <= 1'b1;
          state <= FSPR_HV_DROP;
        end
        FSPR_HV_DROP: if (tdone) begin
          // Leave high voltage modes in the same cycle as reporting
          hv_addr_en_o <= 1'b0;
          hv_oe_en_o   <= 1'b0;
          chip_sel_n_o <= 1'b1;
          done_o       <= 1'b1;
          busy_o       <= 1'b0;
          state        <= FSPR_IDLE;
        end
        FSPR_RD_WAIT: begin
          out_strobe_n_o <= 1'b0;
          if (tdone) begin
            // Sample protection result on the lsb
            rd_data_o      <= low_data_outputs_i;
            protected_o    <= low_data_outputs_i[0];
            out_strobe_n_o <= 1'b1;
            chip_sel_n_o   <= 1'b1;
            hv_addr_en_o   <= 1'b0;
            done_o         <= 1'b1;
            busy_o         <= 1'b0;
            state          <= FSPR_IDLE;
          end
        end
        FSPR_RB_WAIT: if (rdy_q && ready_busy_line_i) begin
          {addr_o[11:0], wdata_o} <= fspr_cmd(cmd_idx, op == FSPR_OP_RESET);
          chip_sel_n_o   <= 1'b0;
          out_strobe_n_o <= 1'b1;
          wdata_oe_o     <= 1'b1;
          tval  <= TW'(`FSPR_RB_WRITE_CYC);
          tload <= 1'b1;
          state <= FSPR_CMD_SETUP;
        end
        FSPR_CMD_SETUP: if (tdone) begin
          write_strobe_n_o <= 1'b0;
          tval  <= TW'(`FSPR_ACC_CYC);
          tload <= 1'b1;
          state <= FSPR_CMD_LOW;
        end
        FSPR_CMD_LOW: if (tdone) begin
          write_strobe_n_o <= 1'b1;
          tval  <= TW'(`FSPR_ACC_CYC);
          tload <= 1'b1;
          state <= FSPR_CMD_HIGH;
        end
        FSPR_CMD_HIGH: if (tdone) begin
          chip_sel_n_o <= 1'b1;
          wdata_oe_o   <= 1'b0;
          if (cmd_idx == 2'd2) begin
            if (op == FSPR_OP_RESET) begin
              done_o <= 1'b1;
              busy_o <= 1'b0;
              state  <= FSPR_IDLE;
            end else begin
              // Status read at id page high
              addr_o       <= sector_addr_i;
              addr_o[IDPG] <= 1'b1;
              chip_sel_n_o <= 1'b0;
              tval  <= TW'(`FSPR_ACC_CYC);
              tload <= 1'b1;
              state <= FSPR_RD_WAIT;
            end
          end else begin
            cmd_idx <= cmd_idx + 2'd1;
            state   <= FSPR_RB_WAIT;
          end
        end
        FSPR_RST_LOW: if (tdone) begin
          hw_reset_n_o <= 1'b1;
          tval  <= (RDY_BUSY_CYC > RP_BUSY_CYC && alg_busy_i) ?
                   TW'(RDY_BUSY_CYC - RP_BUSY_CYC) : TW'(`FSPR_READY_IDLE_CYC);
          tload <= 1'b1;
          state <= FSPR_RST_WAIT;
        end
        FSPR_RST_WAIT: if (tdone) begin
          done_o <= 1'b1;
          busy_o <= 1'b0;
          state  <= FSPR_IDLE;
        end
        default: state <= FSPR_IDLE;
      endcase
    end
  end

  // Ready seen for one cycle before the command write
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) rdy_q <= 1'b0;
    else           rdy_q <= ready_busy_line_i;
  end
endmodule

// ==== sim/fspr_host_sva.sv ====
`timescale 1ns/1ps
`include "fspr_cfg.svh"
module fspr_host_sva #(
  parameter int AW          = 18,
  parameter int RP_BUSY_CYC = 1000
) (
  input wire logic          clock_i,
  input wire logic          resetn_i,
  input wire logic          alg_busy_i,
  input wire logic          ready_busy_line_i,
  input wire logic [AW-1:0] addr_o,
  input wire logic [7:0]    wdata_o,
  input wire logic          wdata_oe_o,
  input wire logic          chip_sel_n_o,
  input wire logic          out_strobe_n_o,
  input wire logic          write_strobe_n_o,
  input wire logic          hw_reset_n_o,
  input wire logic          hv_addr_en_o,
  input wire logic          hv_oe_en_o,
  input wire logic          hv_reset_en_o
);
  int unsigned rdy_cnt;
  int unsigned lo_cnt;
  logic        long_q;
  // Cycles since ready, reset low width, reset kind
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdy_cnt <= 0;
      lo_cnt <= 0;
      long_q <= 1'b0;
    end else begin
      rdy_cnt <= ready_busy_line_i ? ((rdy_cnt < 99) ? rdy_cnt + 1 : rdy_cnt) : 0;
      lo_cnt <= hw_reset_n_o ? 0 : lo_cnt + 1;
      if ($fell(hw_reset_n_o)) long_q <= alg_busy_i;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  property p_hv_setup;
    $fell(write_strobe_n_o) && hv_oe_en_o |-> $past(hv_addr_en_o && hv_oe_en_o && !chip_sel_n_o, 8);
  endproperty
  a_hv_setup: assert property (p_hv_setup) else $error("high voltage not set up before write");
  property p_hv_hold;
    !write_strobe_n_o && hv_oe_en_o |=> hv_oe_en_o && hv_addr_en_o;
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("high voltage dropped at write pulse");
  property p_unprot_sel;
    !write_strobe_n_o && hv_oe_en_o && addr_o[6] |-> hv_addr_en_o && !chip_sel_n_o && $stable(addr_o);
  endproperty
  a_unprot_sel: assert property (p_unprot_sel) else $error("bad unprotect setup");
  property p_idq_cmd;
    !write_strobe_n_o && !hv_oe_en_o && wdata_o == 8'h90 |-> addr_o[11:0] == 12'h555 && wdata_oe_o;
  endproperty
  a_idq_cmd: assert property (p_idq_cmd) else $error("query command misplaced");
  property p_wr_gate;
    !write_strobe_n_o |-> !chip_sel_n_o && (out_strobe_n_o || hv_oe_en_o);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write strobe without select");
  property p_no_fight;
    !out_strobe_n_o && !chip_sel_n_o |-> !wdata_oe_o;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("data driven during read");
  property p_rdy_wr;
    $fell(write_strobe_n_o) |-> rdy_cnt >= `FSPR_RB_WRITE_CYC;
  endproperty
  a_rdy_wr: assert property (p_rdy_wr) else $error("write too soon after ready");
  property p_rst_busy;
    $rose(hw_reset_n_o) && long_q |-> lo_cnt >= RP_BUSY_CYC;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("busy reset pulse short");
  property p_rst_idle;
    $rose(hw_reset_n_o) && !long_q |-> lo_cnt >= `FSPR_RP_IDLE_CYC;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("idle reset pulse short");
  c_protect: cover property ($fell(write_strobe_n_o) && hv_oe_en_o && !addr_o[6]);
  c_unprot: cover property ($fell(write_strobe_n_o) && hv_oe_en_o && addr_o[6]);
  c_rst_busy: cover property ($rose(hw_reset_n_o) && long_q);
  c_temp: cover property ($rose(hv_reset_en_o));
endmodule
bind fspr_host fspr_host_sva #(.AW(AW), .RP_BUSY_CYC(RP_BUSY_CYC)) u_fspr_host_sva (.clock_i, .resetn_i,
  .alg_busy_i, .ready_busy_line_i, .addr_o, .wdata_o, .wdata_oe_o, .chip_sel_n_o, .out_strobe_n_o,
  .write_strobe_n_o, .hw_reset_n_o, .hv_addr_en_o, .hv_oe_en_o, .hv_reset_en_o);

// ==== sim/fspr_dev_model.sv ====
`timescale 1ns/1ps
module fspr_dev_model #(
  parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'hA5  // Arbitrary value
) (
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  d_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        hva_i,
  input  wire logic        hvo_i,
  input  wire logic        hvr_i,
  output logic [7:0]       q_o,
  output logic             rdy_o
);
  logic [3:0] prot = 4'h0;
  logic       idq = 1'b0;
  logic [1:0] seq = 2'd0;
  logic [7:0] val;
  wire  [1:0] sec = addr_i[17:16];
  assign rdy_o = 1'b1;
  // Protect element and command decode at write end
  always @(posedge we_n_i) begin
    if (hva_i && hvo_i && !cs_n_i) begin
      if (addr_i[6]) prot <= 4'h0;
      else prot[sec] <= 1'b1;
    end else if (!cs_n_i && oe_n_i) begin
      seq <= 2'd0;
      if (seq == 2'd0 && d_i == 8'hAA && addr_i[11:0] == 12'h555) seq <= 2'd1;
      else if (seq == 2'd1 && d_i == 8'h55 && addr_i[11:0] == 12'hAAA) seq <= 2'd2;
      else if (seq == 2'd2 && d_i == 8'h90 && addr_i[11:0] == 12'h555) idq <= 1'b1;
      else if (d_i == 8'hF0) idq <= 1'b0;
    end
  end
  // Hardware reset returns to array reads
  always @(negedge rst_n_i) begin
    idq <= 1'b0;
    seq <= 2'd0;
  end
  // Read path, bus shows inverse when not read
  always_comb begin
    if (hva_i || idq) val = addr_i[1] ? {7'h0, prot[sec] & !hvr_i} : (addr_i[0] ? DEV_ID : MFR_ID);
    else val = 8'hFF;
  end
  assign q_o = (!cs_n_i && !oe_n_i) ? val : ~val;
endmodule

// ==== sim/fspr_host_tb_top.sv ====
`timescale 1ns/1ps
module fspr_host_tb_top;
  import fspr_pkg::*;
  logic clock_i, resetn_i, req_i, alg_busy_i, ready_busy_line_i, busy_o, done_o, protected_o, wdata_oe_o;
  logic chip_sel_n_o, out_strobe_n_o, write_strobe_n_o, hw_reset_n_o, hv_addr_en_o, hv_oe_en_o, hv_reset_en_o;
  logic [17:0] sector_addr_i, addr_o;
  logic [7:0]  low_data_outputs_i, rd_data_o, wdata_o;
  fspr_op_t    op_i;
  int          failures, cmp_count, rst_lo;
  fspr_host #(.AW(18), .RP_BUSY_CYC(20), .RDY_BUSY_CYC(40), .WPP1_CYC(20), .WPP2_CYC(30)) u_fspr_host (.clock_i,
    .resetn_i, .req_i, .op_i, .sector_addr_i, .alg_busy_i, .low_data_outputs_i, .ready_busy_line_i, .busy_o,
    .done_o, .rd_data_o, .protected_o, .addr_o, .wdata_o, .wdata_oe_o, .chip_sel_n_o, .out_strobe_n_o,
    .write_strobe_n_o, .hw_reset_n_o, .hv_addr_en_o, .hv_oe_en_o, .hv_reset_en_o);
  fspr_dev_model u_fspr_dev_model (.addr_i(addr_o), .d_i(wdata_o), .cs_n_i(chip_sel_n_o), .oe_n_i(out_strobe_n_o),
    .we_n_i(write_strobe_n_o), .rst_n_i(hw_reset_n_o), .hva_i(hv_addr_en_o), .hvo_i(hv_oe_en_o),
    .hvr_i(hv_reset_en_o), .q_o(low_data_outputs_i), .rdy_o(ready_busy_line_i));
  task automatic results();
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One request, bounded wait for done
  task automatic run_op(fspr_op_t op, logic [17:0] sa);
    int n;
    @(posedge clock_i);
    req_i <= 1'b1;
    op_i <= op;
    sector_addr_i <= sa;
    @(posedge clock_i);
    req_i <= 1'b0;
    rst_lo = 0;
    for (n = 0; n < 5000; n++) begin
      @(negedge clock_i);
      if (hw_reset_n_o === 1'b0) rst_lo++;
      if (done_o === 1'b1) break;
    end
    if (n == 5000) begin
      failures++;
      $display("MISMATCH done_o expected 1 seen 0");
      results();
    end
  endtask
  task automatic t_protect();
    run_op(FSPR_OP_PROTECT, 18'h20000);
    run_op(FSPR_OP_VERIFY, 18'h20000);
    chk("verify_sec2", 8'h01, rd_data_o);
    chk("protected", 8'h01, {7'h0, protected_o});
    run_op(FSPR_OP_VERIFY, 18'h1FFFD);
    chk("verify_sec1", 8'h00, rd_data_o);
  endtask
  task automatic t_temp();
    run_op(FSPR_OP_TEMP_ON, 18'h20000);
    chk("temp_on", 8'h01, {7'h0, hv_reset_en_o});
    run_op(FSPR_OP_VERIFY, 18'h20000);
    chk("temp_verify", 8'h00, rd_data_o);
    run_op(FSPR_OP_TEMP_OFF, 18'h20000);
    run_op(FSPR_OP_VERIFY, 18'h20000);
    chk("temp_off", 8'h01, rd_data_o);
  endtask
  task automatic t_unprotect();
    run_op(FSPR_OP_QUERY, 18'h20000);
    chk("query_sec2", 8'h01, rd_data_o);
    for (int s = 0; s < 4; s++) run_op(FSPR_OP_PROTECT, 18'(s << 16));
    run_op(FSPR_OP_UNPROTECT, 18'h00040);
    for (int s = 0; s < 4; s++) begin
      run_op(FSPR_OP_QUERY, 18'(s << 16));
      chk("query_clear", 8'h00, rd_data_o);
    end
  endtask
  // Reset op is the command write; temp off gives the hardware pulse
  task automatic t_reset();
    chk("query_left_on", 8'h01, {7'h0, u_fspr_dev_model.idq});
    run_op(FSPR_OP_RESET, 18'h0);
    chk("cmd_reset", 8'h00, {7'h0, u_fspr_dev_model.idq});
    chk("cmd_no_pulse", 8'h00, {7'h0, rst_lo != 0});
    run_op(FSPR_OP_TEMP_OFF, 18'h0);
    chk("rst_idle", 8'h01, {7'h0, rst_lo >= 50});
    @(posedge clock_i);
    alg_busy_i <= 1'b1;
    run_op(FSPR_OP_TEMP_OFF, 18'h0);
    chk("rst_busy", 8'h01, {7'h0, rst_lo >= 20});
    @(posedge clock_i);
    alg_busy_i <= 1'b0;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Main sequence
  initial begin
    resetn_i = 1'b0;
    req_i = 1'b0;
    alg_busy_i = 1'b0;
    op_i = FSPR_OP_VERIFY;
    sector_addr_i = '0;
    failures = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    chk("idle_strobes", 8'h0F, {4'h0, chip_sel_n_o, out_strobe_n_o, write_strobe_n_o, hw_reset_n_o});
    t_protect();
    t_temp();
    t_unprotect();
    t_reset();
    results();
  end
endmodule
